// ===== hw/smc_regs.svh
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// Clock rate in MHz
`define SMC_CLK_MHZ          100
// Reset delay time in microseconds
`define SMC_RESET_DELAY_US   10
// Reset delay time in clock cycles
`define SMC_RESET_DELAY_CYC  (`SMC_RESET_DELAY_US * `SMC_CLK_MHZ)
// Device state field codes
`define SMC_DEV_NONE         2'h0
`define SMC_DEV_RESTART      2'h1
`define SMC_DEV_SLEEP        2'h2
// Watchdog fail count codes
`define SMC_WD_NONE          2'h0
`define SMC_WD_ONE           2'h1
`define SMC_WD_TWO           2'h2
// Watchdog period default after reset release
`define SMC_WD_PERIOD_DEF    3'h4
// Wake inputs lost to the measurement function
`define SMC_WAKE_MEASURE_SELECT_MASK     3'h3

`endif

// ===== hw/smc_pkg.sv
`default_nettype none
package smc_pkg;
   // Operating modes, one-hot
   typedef enum logic [4:0] {
      SMC_NORMAL   = 5'h01,
      SMC_STOP     = 5'h02,
      SMC_SLEEP    = 5'h04,
      SMC_RESTART  = 5'h08,
      SMC_FAILSAFE = 5'h10
   } smc_state_t;
   // Transceiver modes
   typedef enum logic [1:0] {
      SMC_XCVR_OFF  = 2'h0,
      SMC_XCVR_WAKE = 2'h1,
      SMC_XCVR_RXO  = 2'h2,
      SMC_XCVR_ON   = 2'h3
   } smc_xcvr_t;
   // Settings made in Normal Mode
   typedef struct packed {
      logic       aux;
      logic       ext;
      logic [3:0] hs;
      logic [3:0] cs;
      logic       cw;
      logic [2:0] wk_en;
   } smc_cfg_t;
   // Status bits reported after return to Normal
   typedef struct packed {
      logic [1:0] dev;
      logic [1:0] watchdog_fail_count;
      logic       uv;
      logic       ov;
      logic       spi_fail;
      logic       can;
      logic       lin;
      logic [2:0] wk;
   } smc_status_t;
endpackage : smc_pkg
`default_nettype wire

// ===== hw/smc_mode_ctrl.sv
`include "smc_regs.svh"
`default_nettype none
// Operation
// - Wake on CAN, LIN or wake input in Sleep goes Restart then Normal, records source.
// - Normal Mode settings stay unchanged throughout Sleep.
// - On Sleep entry on or receive-only transceivers become wake capable.
// - In Sleep cyclic wake is unavailable and the watchdog stops.
// - No SPI transaction is accepted in Sleep.
// - Sleep entry reports device state code 10.
// - Sleep request with no wake source sets SPI fault and enters Restart.
// - Wake flags still set at Sleep entry cause immediate wake through Restart.
// - Wake inputs one and two are no wake source under measurement select.
// - Main undervoltage in Normal or Stop enters Restart.
// - Main overvoltage enters Restart only with reset enable and pin level one.
// - First watchdog failure enters Restart, except Fail-Safe in configuration two.
// - Wakes from Sleep or Fail-Safe and thermal release route through Restart.
// - Restart leaves to Normal by itself and clears the mode bits.
// - Reset output low throughout Restart, released after reset delay at Normal.
// - Reset output rising edge starts long open window, period reloads to 100.
// - Fail outputs set on a second watchdog fault (first only with config bit) or overvoltage faults, unchanged leaving Restart.
// - Restart entry disables aux regulator and high-side outputs; ext regulator kept.
// - In Restart transceivers are wake capable if previously active, else off.
// - SPI transactions in Restart are ignored.
// - Restart from Normal or Stop reports 01, watchdog count, voltage flags.
// - Cyclic sensing runs in Sleep but stops where its switch has faulted.
// - Overvoltage with reset enable and pin level zero enters Fail-Safe.
module smc_mode_ctrl (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                can_wake,
   input  wire logic                lin_wake,
   input  wire logic [2:0]          wake_input,
   input  wire logic                main_undervoltage,
   input  wire logic                main_overvoltage,
   input  wire logic                normal_req,
   input  wire logic                stop_req,
   input  wire logic                sleep_req,
   input  wire logic                watchdog_fail,
   input  wire logic                thermal_shutdown_level_two_release,
   input  wire logic                status_clear,
   input  wire logic                wake_status_pending,
   input  wire logic                wake_measure_select,
   input  wire logic                overvoltage_reset_enable,
   input  wire logic                pin_config_level,
   input  wire logic                config_bit,
   input  wire smc_pkg::smc_cfg_t   cfg_in,
   input  wire smc_pkg::smc_xcvr_t  can_mode_in,
   input  wire smc_pkg::smc_xcvr_t  lin_mode_in,
   input  wire logic                wd_period_wr,
   input  wire logic [2:0]          wd_period_in,
   input  wire logic [3:0]          hs_fault,
   output smc_pkg::smc_state_t      mode,
   output logic                     spi_accept,
   output logic                     reset_output_n,
   output logic                     wd_long_window_start,
   output logic [2:0]               watchdog_period,
   output logic                     watchdog_run,
   output logic                     cyclic_wake_en,
   output logic [3:0]               cyclic_sense_en,
   output logic                     mode_bits_clear,
   output logic                     fail_output_active,
   output logic                     aux_regulator_en,
   output logic                     ext_transistor_regulator_en,
   output logic [3:0]               high_side_en,
   output smc_pkg::smc_xcvr_t       can_mode,
   output smc_pkg::smc_xcvr_t       lin_mode,
   output smc_pkg::smc_status_t     status
);
   localparam logic [9:0] RD_LAST = 10'(`SMC_RESET_DELAY_CYC - 1);

   smc_pkg::smc_state_t  st_q, st_d;
   smc_pkg::smc_cfg_t    cfg_q, cfg_d;
   smc_pkg::smc_status_t sts_q, sts_d;
   smc_pkg::smc_xcvr_t   can_q, can_d, lin_q, lin_d;
   logic [9:0]           cnt_q, cnt_d;
   logic [10:0]          age_q, age_d;
   logic                 fo_q, fo_d, ro_n_q, ro_n_d, wds_q, wds_d, mclr_q, mclr_d;
   logic                 run_q, run_d, cw_q, cw_d;
   logic [3:0]           cse_q, cse_d;
   logic [2:0]           wdp_q, wdp_d;
   logic [6:0]           sync1_q, sync2_q;
   logic                 can_s, lin_s, uv_s, ov_s, awake;
   logic [2:0]           wk_s, wk_ok;
   logic [4:0]           hits;

   // Pin inputs pass two flip-flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 7'h00;
         sync2_q <= 7'h00;
      end else begin
         sync1_q <= {main_overvoltage, main_undervoltage, wake_input, lin_wake, can_wake};
         sync2_q <= sync1_q;
      end
   end
   assign {ov_s, uv_s, wk_s, lin_s, can_s} = sync2_q;

   // Measurement select removes wake inputs one and two
   assign wk_ok = wake_measure_select ? (cfg_q.wk_en & ~`SMC_WAKE_MEASURE_SELECT_MASK) : cfg_q.wk_en;
   assign hits = {wk_s & wk_ok,
                  lin_s & (lin_q != smc_pkg::SMC_XCVR_OFF),
                  can_s & (can_q != smc_pkg::SMC_XCVR_OFF)};
   assign awake = (st_q == smc_pkg::SMC_NORMAL) || (st_q == smc_pkg::SMC_STOP);
   assign spi_accept = awake;

   // Transceiver on Sleep entry
   function automatic smc_pkg::smc_xcvr_t xc_sleep(input smc_pkg::smc_xcvr_t m);
      xc_sleep = (m == smc_pkg::SMC_XCVR_ON || m == smc_pkg::SMC_XCVR_RXO) ?
                 smc_pkg::SMC_XCVR_WAKE : m;
   endfunction : xc_sleep

   // Transceiver on Restart entry
   function automatic smc_pkg::smc_xcvr_t xc_restart(input smc_pkg::smc_xcvr_t m);
      xc_restart = (m == smc_pkg::SMC_XCVR_OFF) ? smc_pkg::SMC_XCVR_OFF :
                   smc_pkg::SMC_XCVR_WAKE;
   endfunction : xc_restart

   // Mode state machine next values
   always_comb begin
      st_d   = st_q;
      cfg_d  = cfg_q;
      sts_d  = status_clear ? '0 : sts_q;
      can_d  = can_q;
      lin_d  = lin_q;
      cnt_d  = cnt_q;
      fo_d   = fo_q;
      mclr_d = 1'b0;
      case (st_q)
         smc_pkg::SMC_NORMAL, smc_pkg::SMC_STOP: begin
            if (st_q == smc_pkg::SMC_NORMAL) begin
               cfg_d = cfg_in;
               can_d = can_mode_in;
               lin_d = lin_mode_in;
            end
            if (uv_s) begin
               st_d = smc_pkg::SMC_RESTART;
               sts_d.uv = 1'b1;
               sts_d.dev = `SMC_DEV_RESTART;
            end else if (ov_s && overvoltage_reset_enable) begin
               st_d = pin_config_level ? smc_pkg::SMC_RESTART :
                      smc_pkg::SMC_FAILSAFE;
               sts_d.ov = 1'b1;
               sts_d.dev = `SMC_DEV_RESTART;
               fo_d = 1'b1;
            end else if (watchdog_fail) begin
               sts_d.dev = `SMC_DEV_RESTART;
               if (sts_q.watchdog_fail_count == `SMC_WD_NONE) begin
                  sts_d.watchdog_fail_count = `SMC_WD_ONE;
                  fo_d = fo_q | config_bit;
                  st_d = (config_bit && !pin_config_level) ? smc_pkg::SMC_FAILSAFE :
                         smc_pkg::SMC_RESTART;
               end else begin
                  sts_d.watchdog_fail_count = `SMC_WD_TWO;
                  fo_d = 1'b1;
                  st_d = (!config_bit && !pin_config_level) ? smc_pkg::SMC_FAILSAFE :
                         smc_pkg::SMC_RESTART;
               end
            end else if (sleep_req) begin
               if (st_q == smc_pkg::SMC_STOP || (wk_ok == 3'h0 &&
                   can_mode_in == smc_pkg::SMC_XCVR_OFF &&
                   lin_mode_in == smc_pkg::SMC_XCVR_OFF)) begin
                  sts_d.spi_fail = 1'b1;
                  sts_d.dev = `SMC_DEV_RESTART;
                  st_d = smc_pkg::SMC_RESTART;
               end else begin
                  sts_d.dev = `SMC_DEV_SLEEP;
                  st_d = smc_pkg::SMC_SLEEP;
               end
            end else if (stop_req && st_q == smc_pkg::SMC_NORMAL) begin
               st_d = smc_pkg::SMC_STOP;
            end else if (normal_req && st_q == smc_pkg::SMC_STOP) begin
               st_d = smc_pkg::SMC_NORMAL;
            end
         end
         smc_pkg::SMC_SLEEP: begin
            // Settings are not touched here
            if (hits != 5'h00 || wake_status_pending) begin
               st_d = smc_pkg::SMC_RESTART;
               {sts_d.wk, sts_d.lin, sts_d.can} = {sts_q.wk, sts_q.lin, sts_q.can} | hits;
            end
         end
         smc_pkg::SMC_RESTART: begin
            cnt_d = cnt_q + 10'h001;
            if (cnt_q == RD_LAST) begin
               st_d = smc_pkg::SMC_NORMAL;
               mclr_d = 1'b1;
            end
         end
         smc_pkg::SMC_FAILSAFE: begin
            if (can_s || lin_s || (wk_s & (wake_measure_select ?
                ~`SMC_WAKE_MEASURE_SELECT_MASK : 3'h7)) != 3'h0 || thermal_shutdown_level_two_release) begin
               st_d = smc_pkg::SMC_RESTART;
            end
         end
         default: begin
            st_d = smc_pkg::SMC_RESTART;
         end
      endcase
      // Entry actions
      if (st_d == smc_pkg::SMC_SLEEP && st_q != smc_pkg::SMC_SLEEP) begin
         can_d = xc_sleep(can_d);
         lin_d = xc_sleep(lin_d);
      end
      if (st_d == smc_pkg::SMC_RESTART && st_q != smc_pkg::SMC_RESTART) begin
         cfg_d.aux = 1'b0;
         cfg_d.hs = 4'h0;
         cnt_d = 10'h000;
         can_d = xc_restart(can_q);
         lin_d = xc_restart(lin_q);
      end
      if (st_d == smc_pkg::SMC_FAILSAFE) begin
         fo_d = 1'b1;
      end
   end

   // Mode state machine registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q  <= smc_pkg::SMC_RESTART;
         cfg_q <= '0;
         sts_q <= '0;
         can_q <= smc_pkg::SMC_XCVR_OFF;
         lin_q <= smc_pkg::SMC_XCVR_OFF;
         cnt_q <= 10'h000;
         fo_q  <= 1'b0;
         mclr_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cfg_q <= cfg_d;
         sts_q <= sts_d;
         can_q <= can_d;
         lin_q <= lin_d;
         cnt_q <= cnt_d;
         fo_q  <= fo_d;
         mclr_q <= mclr_d;
      end
   end

   // Reset output, watchdog, enables and restart age next values
   always_comb begin
      age_d  = (st_q == smc_pkg::SMC_RESTART) ? age_q + 11'h001 : 11'h000;
      ro_n_d = (st_d == smc_pkg::SMC_NORMAL) || (st_d == smc_pkg::SMC_STOP);
      wds_d  = ro_n_d && !ro_n_q;
      wdp_d  = wdp_q;
      if (wds_d) begin
         wdp_d = `SMC_WD_PERIOD_DEF;
      end else if (wd_period_wr && st_q == smc_pkg::SMC_NORMAL) begin
         wdp_d = wd_period_in;
      end
      run_d = ro_n_d;
      cw_d  = cfg_d.cw && ro_n_d;
      cse_d = cfg_d.cs & ~hs_fault;
   end

   // Reset output, watchdog and enables registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age_q  <= 11'h000;
         ro_n_q <= 1'b0;
         wds_q  <= 1'b0;
         wdp_q  <= `SMC_WD_PERIOD_DEF;
         run_q  <= 1'b0;
         cw_q   <= 1'b0;
         cse_q  <= 4'h0;
      end else begin
         age_q  <= age_d;
         ro_n_q <= ro_n_d;
         wds_q  <= wds_d;
         wdp_q  <= wdp_d;
         run_q  <= run_d;
         cw_q   <= cw_d;
         cse_q  <= cse_d;
      end
   end

   assign mode                        = st_q;
   assign reset_output_n              = ro_n_q;
   assign wd_long_window_start        = wds_q;
   assign watchdog_period             = wdp_q;
   assign watchdog_run                = run_q;
   assign cyclic_wake_en              = cw_q;
   assign cyclic_sense_en             = cse_q;
   assign mode_bits_clear             = mclr_q;
   assign fail_output_active          = fo_q;
   assign aux_regulator_en            = cfg_q.aux;
   assign ext_transistor_regulator_en = cfg_q.ext;
   assign high_side_en                = cfg_q.hs;
   assign can_mode                    = can_q;
   assign lin_mode                    = lin_q;
   assign status                      = sts_q;

   // Checks
   localparam logic [10:0] RD_CAP = 11'(`SMC_RESET_DELAY_CYC);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_enter_restart;
      (st_q != smc_pkg::SMC_RESTART) ##1 (st_q == smc_pkg::SMC_RESTART);
   endsequence
   sequence s_exit_restart;
      (st_q == smc_pkg::SMC_RESTART) ##1 (st_q == smc_pkg::SMC_NORMAL);
   endsequence

   property p_restart_leaves;
      (st_q == smc_pkg::SMC_RESTART) |-> (age_q < RD_CAP);
   endproperty
   a_restart_leaves: assert property (p_restart_leaves)
      else $error("restart did not end in normal");

   property p_ro_release;
      s_exit_restart |-> reset_output_n && wd_long_window_start &&
                         (watchdog_period == 3'h4) && mode_bits_clear;
   endproperty
   a_ro_release: assert property (p_ro_release)
      else $error("reset release or window start wrong");

   property p_ro_low;
      s_enter_restart |-> !reset_output_n [*8];
   endproperty
   a_ro_low: assert property (p_ro_low)
      else $error("reset output not low in restart");

   property p_restart_off;
      s_enter_restart |-> !aux_regulator_en && (high_side_en == 4'h0);
   endproperty
   a_restart_off: assert property (p_restart_off)
      else $error("outputs left on at restart");

   property p_sleep_hold;
      (st_q == smc_pkg::SMC_SLEEP) ##1 (st_q == smc_pkg::SMC_SLEEP) |->
         $stable(aux_regulator_en) && $stable(high_side_en) && !watchdog_run;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("settings changed in sleep");

   property p_sleep_code;
      (st_q == smc_pkg::SMC_SLEEP) ##1 (st_q == smc_pkg::SMC_RESTART) |->
         status.dev == 2'h2;
   endproperty
   a_sleep_code: assert property (p_sleep_code)
      else $error("sleep code missing after wake");

   property p_no_source;
      (st_q == smc_pkg::SMC_NORMAL) && sleep_req && !uv_s && !watchdog_fail &&
      !(ov_s && overvoltage_reset_enable) && (wk_ok == 3'h0) &&
      (can_mode_in == smc_pkg::SMC_XCVR_OFF) && (lin_mode_in == smc_pkg::SMC_XCVR_OFF)
      |=> (st_q == smc_pkg::SMC_RESTART) && status.spi_fail;
   endproperty
   a_no_source: assert property (p_no_source)
      else $error("sleep without wake source accepted");

   property p_wd_cfg2;
      (st_q == smc_pkg::SMC_NORMAL) && watchdog_fail && !uv_s &&
      !(ov_s && overvoltage_reset_enable) && config_bit && !pin_config_level &&
      (status.watchdog_fail_count == 2'h0) |=> (st_q == smc_pkg::SMC_FAILSAFE) && fail_output_active;
   endproperty
   a_wd_cfg2: assert property (p_wd_cfg2)
      else $error("first watchdog fault in config two");

   property p_uv;
      awake && uv_s |=> (st_q == smc_pkg::SMC_RESTART) && status.uv ##1 !reset_output_n;
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage did not restart");

   property p_fo_kept;
      (st_q == smc_pkg::SMC_RESTART) && fail_output_active |=> fail_output_active;
   endproperty
   a_fo_kept: assert property (p_fo_kept)
      else $error("fail output dropped leaving restart");

   property p_restart_spi;
      (st_q == smc_pkg::SMC_RESTART) && stop_req |=> (st_q != smc_pkg::SMC_STOP);
   endproperty
   a_restart_spi: assert property (p_restart_spi)
      else $error("request taken in restart");
endmodule : smc_mode_ctrl
`default_nettype wire

// ===== hw/smc_pkg_order_note.sv
`default_nettype none
`default_nettype wire

// ===== verif/smc_host.sv
`default_nettype none
// Host model: issues mode requests, watchdog faults and status clears
module smc_host (
   input  wire logic clk,
   input  wire logic reset_output_n,
   output logic      normal_req,
   output logic      stop_req,
   output logic      sleep_req,
   output logic      watchdog_fail,
   output logic      status_clear,
   output logic      wake_status_pending
);
   timeunit 1ns;
   timeprecision 100ps;
   logic             powered;

   // Host supply follows the reset line
   assign powered = reset_output_n;

   // Quiet at power-up, wake flags cleared
   initial begin
      {normal_req, stop_req, sleep_req, watchdog_fail, status_clear} = 5'h0;
      wake_status_pending = 1'b0;
   end

   // One-cycle pulse: 0 normal, 1 stop, 2 sleep, 3 watchdog fault, 4 clear
   task automatic send(input int k);
      // Clear only from a powered host; one idle edge after each pulse
      {normal_req, stop_req, sleep_req, watchdog_fail, status_clear} =
         5'(5'h10 >> k) & {4'hf, powered};
      @(posedge clk);
      #1;
      {normal_req, stop_req, sleep_req, watchdog_fail, status_clear} = 5'h0;
      @(posedge clk);
      #1;
   endtask : send

   // Wake flags left set only when the bench asks
   task automatic set_pending(input logic v);
      wake_status_pending = v;
   endtask : set_pending
endmodule : smc_host
`default_nettype wire

// ===== verif/smc_mode_ctrl_bench.sv
`default_nettype none
// Self-checking bench for the sleep and restart mode controller
module smc_mode_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 clk, rst, can_wake, lin_wake, main_undervoltage, main_overvoltage;
   logic                 thermal_shutdown_level_two_release, wake_measure_select, overvoltage_reset_enable;
   logic                 pin_config_level, config_bit, wd_period_wr, normal_req, stop_req;
   logic                 sleep_req, watchdog_fail, status_clear, wake_status_pending;
   logic                 spi_accept, reset_output_n, wd_long_window_start, watchdog_run;
   logic                 cyclic_wake_en, mode_bits_clear, fail_output_active;
   logic                 aux_regulator_en, ext_transistor_regulator_en, rn_prev;
   logic [2:0]           wake_input, wd_period_in, watchdog_period;
   logic [3:0]           hs_fault, cyclic_sense_en, high_side_en;
   logic [4:0]           src;
   smc_pkg::smc_cfg_t    cfg_in;
   smc_pkg::smc_xcvr_t   can_mode_in, lin_mode_in, can_mode, lin_mode;
   smc_pkg::smc_state_t  mode, mode_prev, em;
   smc_pkg::smc_status_t status;
   int                   n_errors = 0, checks_done = 0, cycles = 0, exp_wd = 0, exp_fo = 0;
   int                   n, t0;
   int                   f_kind [7] = '{0, 1, 2, 2, 1, 1, 2};
   int                   f_en [7]   = '{0, 0, 0, 0, 1, 1, 0};
   int                   f_pin [7]  = '{0, 0, 1, 0, 1, 0, 0};
   int                   f_cfg [7]  = '{0, 0, 0, 0, 0, 0, 1};

   smc_mode_ctrl u_dut (
      .clk, .rst, .can_wake, .lin_wake, .wake_input, .main_undervoltage, .main_overvoltage,
      .normal_req, .stop_req, .sleep_req, .watchdog_fail, .thermal_shutdown_level_two_release, .status_clear,
      .wake_status_pending, .wake_measure_select, .overvoltage_reset_enable,
      .pin_config_level, .config_bit, .cfg_in, .can_mode_in, .lin_mode_in, .wd_period_wr,
      .wd_period_in, .hs_fault, .mode, .spi_accept, .reset_output_n, .wd_long_window_start,
      .watchdog_period, .watchdog_run, .cyclic_wake_en, .cyclic_sense_en, .mode_bits_clear,
      .fail_output_active, .aux_regulator_en, .ext_transistor_regulator_en, .high_side_en,
      .can_mode, .lin_mode, .status
   );

   smc_host u_host (
      .clk, .reset_output_n, .normal_req, .stop_req, .sleep_req, .watchdog_fail,
      .status_clear, .wake_status_pending
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic stop_test;
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   // Bounded wait for a mode
   task automatic wait_mode(input smc_pkg::smc_state_t m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         tick(1);
         n++;
      end
      check("mode", m, mode);
   endtask : wait_mode

   task automatic enter_restart;
      wait_mode(smc_pkg::SMC_RESTART, 8);
      tick(1);
      check("reset_low", 1'b0, reset_output_n);
      check("hs_off", 4'h0, high_side_en);
      check("aux_off", 1'b0, aux_regulator_en);
      check("spi_restart", 1'b0, spi_accept);
   endtask : enter_restart

   task automatic leave_restart;
      wait_mode(smc_pkg::SMC_NORMAL, 1010);
      check("restart_len", 1'b1, 1'((cycles - t0) inside {[999:1002]}));
      check("reset_high", 1'b1, reset_output_n);
   endtask : leave_restart

   // Reference model of fault reactions
   function automatic smc_pkg::smc_state_t model_fault(input int k, input int en, input int pin,
                                                       input int cfg);
      if (k == 0) return smc_pkg::SMC_RESTART;
      if (k == 1) begin
         if (en == 0) return smc_pkg::SMC_NORMAL;
         exp_fo = 1;
         return (pin != 0) ? smc_pkg::SMC_RESTART : smc_pkg::SMC_FAILSAFE;
      end
      exp_wd++;
      if (exp_wd > 1 || cfg != 0) exp_fo = 1;
      return (pin == 0 && ((exp_wd > 1) != (cfg != 0))) ? smc_pkg::SMC_FAILSAFE :
             smc_pkg::SMC_RESTART;
   endfunction : model_fault

   // Restart start, release edge checks, mode bit clear and timeout
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (rst || mode !== smc_pkg::SMC_RESTART) t0 <= cycles;
      rn_prev <= reset_output_n;
      mode_prev <= mode;
      if (!rst && rn_prev === 1'b0 && reset_output_n === 1'b1) begin
         check("window_start", 1'b1, wd_long_window_start);
         check("wd_period", 3'h4, watchdog_period);
      end
      if (!rst && mode_prev === smc_pkg::SMC_RESTART && mode === smc_pkg::SMC_NORMAL) begin
         check("mode_bits_clear", 1'b1, mode_bits_clear);
      end
      if (cycles == 30000) begin
         n_errors++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      {can_wake, lin_wake, main_undervoltage, main_overvoltage, thermal_shutdown_level_two_release} = 5'h0;
      {wake_measure_select, overvoltage_reset_enable, pin_config_level, config_bit} = 4'h0;
      {wd_period_wr, wake_input, wd_period_in, hs_fault} = 11'h0;
      cfg_in = 14'h0;
      can_mode_in = smc_pkg::SMC_XCVR_ON;
      lin_mode_in = smc_pkg::SMC_XCVR_RXO;
      rst = 1'b1;
      void'($urandom(32'ha90cf54a));
      tick(16);
      check("mode_in_reset", smc_pkg::SMC_RESTART, mode);
      check("reset_in_reset", 1'b0, reset_output_n);
      rst = 1'b0;
      leave_restart();
      // Sleep and wake on every source, last pass with measurement select
      for (int i = 0; i < 6; i++) begin
         cfg_in = 14'($urandom);
         cfg_in.wk_en = 3'h7;
         hs_fault = 4'($urandom);
         wake_measure_select = (i == 5);
         can_mode_in = smc_pkg::smc_xcvr_t'(2'($urandom_range(3, 1)));
         lin_mode_in = smc_pkg::smc_xcvr_t'(2'($urandom_range(3, 1)));
         wd_period_in = 3'($urandom_range(3, 0));
         wd_period_wr = (wd_period_in != 3'h4);
         tick(1);
         wd_period_wr = 1'b0;
         check("period_write", wd_period_in, watchdog_period);
         u_host.send(4);
         u_host.send(2);
         wait_mode(smc_pkg::SMC_SLEEP, 4);
         tick(2);
         check("dev_sleep", 2'h2, status.dev);
         check("can_sleep", smc_pkg::SMC_XCVR_WAKE, can_mode);
         check("lin_sleep", smc_pkg::SMC_XCVR_WAKE, lin_mode);
         check("wd_run", 1'b0, watchdog_run);
         check("cyc_wake", 1'b0, cyclic_wake_en);
         check("hs_held", cfg_in.hs, high_side_en);
         check("aux_held", cfg_in.aux, aux_regulator_en);
         check("sense", cfg_in.cs & ~hs_fault, cyclic_sense_en);
         check("spi_sleep", 1'b0, spi_accept);
         u_host.send(0);
         if (i == 5) wake_input = 3'h3;
         tick(6);
         check("mode_held", smc_pkg::SMC_SLEEP, mode);
         src = (i == 5) ? 5'h04 : 5'(5'h10 >> i);
         {can_wake, lin_wake, wake_input} = src;
         enter_restart();
         {can_wake, lin_wake, wake_input} = 5'h0;
         check("ext_kept", cfg_in.ext, ext_transistor_regulator_en);
         check("can_restart", smc_pkg::SMC_XCVR_WAKE, can_mode);
         u_host.send(0);
         leave_restart();
         check("wake_src", src, status[4:0]);
         check("dev_after", 2'h2, status.dev);
      end
      // Sleep refused when only masked wake inputs remain
      cfg_in.wk_en = 3'h3;
      can_mode_in = smc_pkg::SMC_XCVR_OFF;
      lin_mode_in = smc_pkg::SMC_XCVR_OFF;
      u_host.send(4);
      u_host.send(2);
      enter_restart();
      check("can_off", smc_pkg::SMC_XCVR_OFF, can_mode);
      leave_restart();
      check("spi_fail", 1'b1, status.spi_fail);
      // Sleep with wake flags still set wakes at once
      cfg_in.wk_en = 3'h7;
      wake_measure_select = 1'b0;
      can_mode_in = smc_pkg::SMC_XCVR_ON;
      u_host.set_pending(1'b1);
      u_host.send(2);
      enter_restart();
      u_host.set_pending(1'b0);
      leave_restart();
      // Fault reactions against the reference model
      u_host.send(4);
      for (int i = 0; i < 7; i++) begin
         overvoltage_reset_enable = f_en[i][0];
         pin_config_level = f_pin[i][0];
         config_bit = f_cfg[i][0];
         if (i == 0) begin
            u_host.send(1);
            wait_mode(smc_pkg::SMC_STOP, 4);
         end
         if (i == 6) begin
            u_host.send(4);
            exp_wd = 0;
         end
         em = model_fault(f_kind[i], f_en[i], f_pin[i], f_cfg[i]);
         main_undervoltage = (f_kind[i] == 0);
         main_overvoltage = (f_kind[i] == 1);
         if (f_kind[i] == 2) u_host.send(3);
         if (em == smc_pkg::SMC_RESTART) enter_restart();
         else wait_mode(em, 8);
         tick(6);
         check("mode_fault", em, mode);
         {main_undervoltage, main_overvoltage} = 2'h0;
         check("fail_out", exp_fo[0], fail_output_active);
         if (em == smc_pkg::SMC_FAILSAFE) begin
            thermal_shutdown_level_two_release = (mode === smc_pkg::SMC_FAILSAFE);
            tick(1);
            thermal_shutdown_level_two_release = 1'b0;
            enter_restart();
         end
         if (em != smc_pkg::SMC_NORMAL) begin
            leave_restart();
            check("fail_kept", exp_fo[0], fail_output_active);
            check("dev_fault", 2'h1, status.dev);
            if (f_kind[i] == 0) check("uv_flag", 1'b1, status.uv);
            if (f_kind[i] == 1) check("ov_flag", 1'b1, status.ov);
            if (f_kind[i] == 2) check("wd_count", exp_wd[1:0], status.watchdog_fail_count);
         end
      end
      stop_test();
   end
endmodule : smc_mode_ctrl_bench
`default_nettype wire
